// ==== logic/rfd_fault_select.sv ====
// Resolver fault detection, tracking loop, held registers and read port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module rfd_fault_select #(
   parameter logic [11:0] LOS_MIN = rfd_pkg::LOS_MIN_DEF,
   parameter logic [11:0] DOS_MAX = rfd_pkg::DOS_MAX_DEF,
   parameter logic [11:0] MISMATCH_MAX = rfd_pkg::MISMATCH_DEF,
   parameter logic [13:0] EXC_HALF_A = 14'(rfd_pkg::EXC_HALF_10K),
   parameter logic [13:0] EXC_HALF_B = 14'(rfd_pkg::EXC_HALF_12K),
   parameter logic [13:0] EXC_HALF_C = 14'(rfd_pkg::EXC_HALF_15K),
   parameter logic [13:0] EXC_HALF_D = 14'(rfd_pkg::EXC_HALF_20K)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Front end, same clock
   input wire logic [11:0] input_angle,
   input wire logic [11:0] monitor_mag,
   // Control pins
   input wire logic sample_n,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic position_velocity_select,
   input wire logic serial_port_select_n,
   input wire logic excitation_freq_sel_0,
   input wire logic excitation_freq_sel_1,
   // Data pins
   output logic [9:0] low_data_bits_out,
   output logic [9:0] low_data_bits_oe_n,
   input wire logic data_bit_ten_in,
   output logic data_bit_ten_out,
   output logic data_bit_ten_oe_n,
   output logic data_bit_eleven_out,
   output logic data_bit_eleven_oe_n,
   // Fault and excitation pins
   output logic signal_degraded_flag_n,
   output logic tracking_lost_flag_n,
   output logic excitation_out,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [rfd_pkg::NPIN-1:0] pin_raw;
   logic [rfd_pkg::NPIN-1:0] s1_q;
   logic [rfd_pkg::NPIN-1:0] s2_q;
   logic [rfd_pkg::NPIN-1:0] s3_q;
   logic [rfd_pkg::NPIN-1:0] pin_q;
   logic [rfd_pkg::NPIN-1:0] pin_prev_q;
   assign pin_raw = {data_bit_ten_in, excitation_freq_sel_1, excitation_freq_sel_0, serial_port_select_n,
                     position_velocity_select, read_n, chip_select_n, sample_n};
   genvar gi;
   generate
      for (gi = 0; gi < rfd_pkg::NPIN; gi++) begin : g_sync
         // A change counts only once the second and third stages agree
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               s1_q[gi] <= rfd_pkg::PIN_RESET[gi];
               s2_q[gi] <= rfd_pkg::PIN_RESET[gi];
               s3_q[gi] <= rfd_pkg::PIN_RESET[gi];
               pin_q[gi] <= rfd_pkg::PIN_RESET[gi];
               pin_prev_q[gi] <= rfd_pkg::PIN_RESET[gi];
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               pin_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
               pin_prev_q[gi] <= pin_q[gi];
            end
         end
      end
   endgenerate
   wire sample_rise = pin_q[rfd_pkg::PIN_SAMPLE] & ~pin_prev_q[rfd_pkg::PIN_SAMPLE];
   wire sample_fall = ~pin_q[rfd_pkg::PIN_SAMPLE] & pin_prev_q[rfd_pkg::PIN_SAMPLE];
   wire cs_act = ~pin_q[rfd_pkg::PIN_CS];
   wire rd_act = ~pin_q[rfd_pkg::PIN_RD];
   wire rd_fall = rd_act & pin_prev_q[rfd_pkg::PIN_RD];
   wire serial_mode = ~pin_q[rfd_pkg::PIN_SERSEL];
   // Two agreeing samples per level keep a 25 MHz serial clock inside the 200 MHz sampler
   wire sclk_fall = ~pin_q[rfd_pkg::PIN_SCLK] & pin_prev_q[rfd_pkg::PIN_SCLK];
   wire pv_sel = pin_q[rfd_pkg::PIN_PVSEL];
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] rdata_d;
   logic [31:0] reg_rdata_q;
   wire detect_en = ctrl_q[rfd_pkg::CTRL_DETECT_EN];
   // ----------------------------------------------------------------
   // Tracking loop
   // ----------------------------------------------------------------
   logic [11:0] pos_q;
   logic [11:0] pos_hold_q;
   logic [11:0] vel_q;
   logic [11:0] vel_hold_q;
   logic [11:0] vwin_q;
   logic signed [12:0] vacc_q;
   wire [11:0] err = input_angle - pos_q;
   // Never rests: at zero error the step still moves, so a 180 degree null cannot hold
   wire step_up = ~err[11];
   wire [11:0] pos_d = step_up ? pos_q + 12'h0001 : pos_q - 12'h0001;
   wire signed [12:0] vacc_d = step_up ? vacc_q + 13'sh0001 : vacc_q - 13'sh0001;
   wire [11:0] vel_sat = (vacc_q > 13'sh07FF) ? 12'h07FF : (vacc_q < -13'sh0800) ? 12'h0800 : vacc_q[11:0];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pos_q <= 12'h0000;
         vacc_q <= 13'sh0000;
         vwin_q <= 12'h0000;
         vel_q <= 12'h0000;
      end else begin
         pos_q <= pos_d;
         vwin_q <= vwin_q + 12'h0001;
         if (vwin_q == rfd_pkg::VEL_WIN_LAST) begin
            vel_q <= vel_sat;
            vacc_q <= 13'sh0000;
         end else begin
            vacc_q <= vacc_d;
         end
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pos_hold_q <= 12'h0000;
         vel_hold_q <= 12'h0000;
      end else if (sample_fall) begin
         pos_hold_q <= pos_q;
         vel_hold_q <= vel_q;
      end
   end
   // ----------------------------------------------------------------
   // Fault conditions
   // ----------------------------------------------------------------
   wire [11:0] err_abs = err[11] ? 12'h0000 - err : err;
   wire [11:0] mis = pos_q - pos_hold_q;
   wire [11:0] mis_abs = mis[11] ? 12'h0000 - mis : mis;
   wire [11:0] vel_abs = vel_q[11] ? 12'h0000 - vel_q : vel_q;
   wire err_big = err_abs > rfd_pkg::ERR_SET_LSB;
   wire err_small = err_abs < rfd_pkg::HYS_CLR_LSB;
   wire mis_big = mis_abs > rfd_pkg::ERR_SET_LSB;
   wire mis_small = mis_abs < rfd_pkg::HYS_CLR_LSB;
   wire overspeed = vel_abs > rfd_pkg::OVERSPEED_STEPS;
   logic [11:0] min_q;
   logic [11:0] max_q;
   wire los_cond = detect_en & (monitor_mag < LOS_MIN);
   wire rng_cond = detect_en & (monitor_mag > DOS_MAX);
   wire mm_cond = detect_en & (max_q >= min_q) & ((max_q - min_q) > MISMATCH_MAX);
   logic los_q;
   logic dos_mm_q;
   logic lot_err_q;
   logic lot_over_q;
   // Extremes restart on a sample rise; mismatch detection waits for fresh samples
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         min_q <= rfd_pkg::MIN_RESET;
         max_q <= rfd_pkg::MAX_RESET;
      end else if (sample_rise) begin
         min_q <= rfd_pkg::MIN_RESET;
         max_q <= rfd_pkg::MAX_RESET;
      end else begin
         min_q <= (monitor_mag < min_q) ? monitor_mag : min_q;
         max_q <= (monitor_mag > max_q) ? monitor_mag : max_q;
      end
   end
   // Set wins over the sample clear so no event is lost
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         los_q <= 1'b0;
         dos_mm_q <= 1'b0;
      end else begin
         los_q <= los_cond | (los_q & ~sample_rise);
         dos_mm_q <= mm_cond | (dos_mm_q & ~sample_rise);
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lot_err_q <= 1'b0;
         lot_over_q <= 1'b0;
      end else begin
         lot_err_q <= (detect_en & (err_big | mis_big)) | (lot_err_q & ~(err_small & mis_small));
         lot_over_q <= (detect_en & overspeed) | (lot_over_q & ~(~overspeed & mis_small));
      end
   end
   wire dos_any = rng_cond | dos_mm_q;
   wire lot_any = lot_err_q | lot_over_q;
   // Priority: loss masks degradation masks tracking
   wire deg_n_d = ~(los_q | dos_any);
   wire trk_n_d = ~(los_q | (~dos_any & lot_any));
   logic deg_n_q;
   logic trk_n_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         deg_n_q <= 1'b1;
         trk_n_q <= 1'b1;
      end else begin
         deg_n_q <= deg_n_d;
         trk_n_q <= trk_n_d;
      end
   end
   assign signal_degraded_flag_n = deg_n_q;
   assign tracking_lost_flag_n = trk_n_q;
   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [11:0] out_q;
   logic [15:0] shift_q;
   logic [9:0] low_out_q;
   logic [9:0] low_oe_n_q;
   logic b11_q;
   logic b11_oe_n_q;
   // Faults stay out of the parallel word; only the serial word carries the two fault flags
   wire [11:0] sel_word = pv_sel ? pos_hold_q : vel_hold_q;
   wire [14:0] ser_body = {sel_word, pv_sel, deg_n_q, trk_n_q};
   wire [15:0] ser_word = {ser_body, ~^ser_body};
   wire load = cs_act & rd_fall;
   wire par_drive = cs_act & rd_act & ~serial_mode;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_q <= 12'h0000;
         shift_q <= 16'h0000;
      end else if (load) begin
         out_q <= sel_word;
         shift_q <= ser_word;
      end else if (serial_mode & cs_act & sclk_fall) begin
         shift_q <= {shift_q[14:0], 1'b0};
      end
   end
   // Pins follow the output register one cycle later; data stays live in a fault
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         low_out_q <= 10'h000;
         low_oe_n_q <= 10'h3FF;
         b11_q <= 1'b0;
         b11_oe_n_q <= 1'b1;
      end else begin
         low_out_q <= out_q[9:0];
         low_oe_n_q <= {10{~par_drive}};
         b11_q <= serial_mode ? shift_q[15] : out_q[11];
         b11_oe_n_q <= ~(par_drive | (serial_mode & cs_act));
      end
   end
   logic b10_q;
   logic b10_oe_n_q;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         b10_q <= 1'b0;
         b10_oe_n_q <= 1'b1;
      end else begin
         b10_q <= out_q[10];
         b10_oe_n_q <= ~par_drive;
      end
   end
   assign low_data_bits_out = low_out_q;
   assign low_data_bits_oe_n = low_oe_n_q;
   assign data_bit_ten_out = b10_q;
   assign data_bit_ten_oe_n = b10_oe_n_q;
   assign data_bit_eleven_out = b11_q;
   assign data_bit_eleven_oe_n = b11_oe_n_q;
   // ----------------------------------------------------------------
   // Excitation divider
   // ----------------------------------------------------------------
   logic [13:0] exc_cnt_q;
   logic exc_q;
   wire [1:0] fs = {pin_q[rfd_pkg::PIN_FS1], pin_q[rfd_pkg::PIN_FS0]};
   wire [13:0] exc_half = (fs == 2'b11) ? EXC_HALF_A : (fs == 2'b10) ? EXC_HALF_B :
                          (fs == 2'b01) ? EXC_HALF_C : EXC_HALF_D;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         exc_cnt_q <= 14'h0000;
         exc_q <= 1'b0;
      end else if (exc_cnt_q >= exc_half - 14'h0001) begin
         exc_cnt_q <= 14'h0000;
         exc_q <= ~exc_q;
      end else begin
         exc_cnt_q <= exc_cnt_q + 14'h0001;
      end
   end
   assign excitation_out = exc_q;
   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire [31:0] status_word = {25'h0000_000, pv_sel, serial_mode, lot_over_q, lot_err_q, dos_mm_q, rng_cond, los_q};
   assign rdata_d = (reg_addr == rfd_pkg::REG_CTRL) ? ctrl_q :
                    (reg_addr == rfd_pkg::REG_STATUS) ? status_word :
                    (reg_addr == rfd_pkg::REG_EXTREMES) ? {4'h0, max_q, 4'h0, min_q} :
                    (reg_addr == rfd_pkg::REG_HELD) ? {4'h0, vel_hold_q, 4'h0, pos_hold_q} : 32'h0000_0000;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= rfd_pkg::CTRL_RESET;
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == rfd_pkg::REG_CTRL) begin
            ctrl_q <= {31'h0000_0000, reg_wdata[rfd_pkg::CTRL_DETECT_EN]};
         end
         reg_rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
      end
   end
   assign reg_rdata = reg_rdata_q;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_LOS_LATCH: assert property (@(posedge clock) disable iff (!rstn)
      los_cond |=> los_q ##1 (!signal_degraded_flag_n && !tracking_lost_flag_n))
      else $error("loss of signal not flagged 00");
   AST_LOS_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
      (los_q && sample_rise && !los_cond) |=> !los_q)
      else $error("sample rise did not clear loss latch");
   AST_LOS_STICKY: assert property (@(posedge clock) disable iff (!rstn)
      (los_q && !sample_rise) |=> los_q)
      else $error("loss latch dropped without sample rise");
   AST_RANGE: assert property (@(posedge clock) disable iff (!rstn)
      (rng_cond && !los_q) |=> !signal_degraded_flag_n && tracking_lost_flag_n)
      else $error("over-range not shown as 01");
   AST_MM_HOLD: assert property (@(posedge clock) disable iff (!rstn)
      (dos_mm_q && !sample_rise) |=> dos_mm_q)
      else $error("mismatch latch dropped early");
   AST_LOT_ERR: assert property (@(posedge clock) disable iff (!rstn)
      (detect_en && err_big) |=> lot_err_q)
      else $error("tracking error did not set flag");
   AST_LOT_HYS: assert property (@(posedge clock) disable iff (!rstn)
      (lot_err_q && !(err_small && mis_small)) |=> lot_err_q)
      else $error("tracking flag cleared above 1 degree");
   AST_OVERSPEED: assert property (@(posedge clock) disable iff (!rstn)
      (lot_over_q && overspeed) |=> lot_over_q)
      else $error("over-speed flag cleared while too fast");
   AST_STEP: assert property (@(posedge clock) disable iff (!rstn)
      rstn |=> (pos_q != $past(pos_q)))
      else $error("tracking loop stood still");
   AST_HOLD: assert property (@(posedge clock) disable iff (!rstn)
      sample_fall |=> (pos_hold_q == $past(pos_q)) && (vel_hold_q == $past(vel_q)))
      else $error("held registers not loaded on sample fall");
   AST_FLOAT: assert property (@(posedge clock) disable iff (!rstn)
      serial_mode |=> low_data_bits_oe_n == 10'h3FF)
      else $error("low data bits driven in serial mode");
   CVR_LOS: cover property (@(posedge clock) disable iff (!rstn) los_q ##1 sample_rise ##2 !los_q);
   CVR_LOT: cover property (@(posedge clock) disable iff (!rstn) lot_err_q ##1 !lot_err_q);
   CVR_PAR_READ: cover property (@(posedge clock) disable iff (!rstn) load && !serial_mode);
   CVR_SER_SHIFT: cover property (@(posedge clock) disable iff (!rstn) serial_mode && cs_act && sclk_fall);
endmodule

// ==== logic/rfd_pkg.sv ====
// Constants shared by the resolver fault detect and output select block
package rfd_pkg;
   // ----------------------------------------------------------------
   // Clock and angle scaling
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 200000000;
   localparam int ANGLE_LSB_PER_TURN = 4096;
   localparam int ERR_SET_DEG = 5;
   localparam int HYS_CLR_DEG = 1;
   localparam logic [11:0] ERR_SET_LSB = 12'(ERR_SET_DEG * ANGLE_LSB_PER_TURN / 360);
   localparam logic [11:0] HYS_CLR_LSB = 12'(HYS_CLR_DEG * ANGLE_LSB_PER_TURN / 360);
   // ----------------------------------------------------------------
   // Velocity measurement and over-speed
   // ----------------------------------------------------------------
   localparam longint MAX_TRACK_RPS = 1000;
   localparam int VEL_WIN_CYCLES = 4096;
   localparam logic [11:0] VEL_WIN_LAST = 12'(VEL_WIN_CYCLES - 1);
   localparam logic [11:0] OVERSPEED_STEPS =
      12'(MAX_TRACK_RPS * ANGLE_LSB_PER_TURN * VEL_WIN_CYCLES / CLK_HZ);
   // ----------------------------------------------------------------
   // Monitor thresholds
   // ----------------------------------------------------------------
   localparam logic [11:0] LOS_MIN_DEF = 12'h0200;
   localparam logic [11:0] DOS_MAX_DEF = 12'h0F00;
   localparam logic [11:0] MISMATCH_DEF = 12'h0100;
   localparam logic [11:0] MIN_RESET = 12'h0FFF;
   localparam logic [11:0] MAX_RESET = 12'h0000;
   // ----------------------------------------------------------------
   // Excitation half periods in cycles
   // ----------------------------------------------------------------
   localparam int EXC_HALF_10K = 10000;
   localparam int EXC_HALF_12K = 8333;
   localparam int EXC_HALF_15K = 6666;
   localparam int EXC_HALF_20K = 5000;
   // ----------------------------------------------------------------
   // Pin synchroniser slots
   // ----------------------------------------------------------------
   localparam int NPIN = 8;
   localparam int PIN_SAMPLE = 0;
   localparam int PIN_CS = 1;
   localparam int PIN_RD = 2;
   localparam int PIN_PVSEL = 3;
   localparam int PIN_SERSEL = 4;
   localparam int PIN_FS0 = 5;
   localparam int PIN_FS1 = 6;
   localparam int PIN_SCLK = 7;
   localparam logic [NPIN-1:0] PIN_RESET = 8'h17;
   // ----------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_EXTREMES = 8'h08;
   localparam logic [7:0] REG_HELD = 8'h0C;
   localparam int CTRL_DETECT_EN = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
endpackage

// ==== test/rfd_fault_select_test.sv ====
// Self-checking bench for the fault detect and output select block
`timescale 1ns/1ps
module rfd_fault_select_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   typedef struct packed {logic [11:0] mag; logic [1:0] smp; logic [1:0] flags;} rfd_row_t;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] input_angle = 12'h0000;
   logic [11:0] monitor_mag = 12'h0800;
   logic fs0 = 1'b1;
   logic fs1 = 1'b1;
   logic ser_n = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire [31:0] reg_rdata;
   wire [9:0] low_out, low_oe_n;
   wire ten_out, ten_oe_n, elev_out, elev_oe_n, dos_n, lot_n, exc;
   wire sample_n, cs_n, rd_n, pvsel, sclk;
   wire ten_in = ten_oe_n ? sclk : ten_out;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int halves [4] = '{10, 8, 6, 5};
   logic [11:0] d, p;
   logic [11:0] oe;
   logic [15:0] w;
   rfd_row_t rows [11] = '{'{12'h0800, 2'h1, 2'h3}, '{12'h0880, 2'h0, 2'h3}, '{12'h0920, 2'h0, 2'h1},
      '{12'h0800, 2'h0, 2'h1}, '{12'h0800, 2'h2, 2'h3}, '{12'h0100, 2'h0, 2'h0}, '{12'h0800, 2'h0, 2'h0},
      '{12'h0800, 2'h2, 2'h3}, '{12'h0F80, 2'h2, 2'h1}, '{12'h0F00, 2'h0, 2'h3}, '{12'h0800, 2'h2, 2'h3}};
   always #2.5 clock = ~clock;
   rfd_fault_select #(.EXC_HALF_A(14'h000A), .EXC_HALF_B(14'h0008), .EXC_HALF_C(14'h0006),
      .EXC_HALF_D(14'h0005)) rfd_fault_select_inst (.clock(clock), .rstn(rstn), .input_angle(input_angle),
      .monitor_mag(monitor_mag), .sample_n(sample_n), .chip_select_n(cs_n), .read_n(rd_n),
      .position_velocity_select(pvsel), .serial_port_select_n(ser_n), .excitation_freq_sel_0(fs0),
      .excitation_freq_sel_1(fs1), .low_data_bits_out(low_out), .low_data_bits_oe_n(low_oe_n),
      .data_bit_ten_in(ten_in), .data_bit_ten_out(ten_out), .data_bit_ten_oe_n(ten_oe_n),
      .data_bit_eleven_out(elev_out), .data_bit_eleven_oe_n(elev_oe_n), .signal_degraded_flag_n(dos_n),
      .tracking_lost_flag_n(lot_n), .excitation_out(exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rfd_host_model rfd_host_model_inst (.clock(clock), .sample_n(sample_n), .chip_select_n(cs_n),
      .read_n(rd_n), .position_velocity_select(pvsel), .serial_clock(sclk),
      .data_pins({elev_out, ten_out, low_out}), .oe_pins({elev_oe_n, ten_oe_n, low_oe_n}),
      .serial_out(elev_out));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", exp, reg_rdata);
   endtask
   // Counts the edges that see the reference high in one half period
   task automatic exc_half(input logic [1:0] sel, input int exp);
      int n;
      n = 0;
      @(posedge clock);
      {fs1, fs0} <= sel;
      repeat (60) @(posedge clock);
      @(posedge exc);
      @(posedge clock);
      while (exc === 1'b1) begin
         n++;
         @(posedge clock);
      end
      check("exc_half", 32'(exp), 32'(n));
   endtask
   task automatic conclude();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      repeat (10) @(posedge clock);
      check("flags_reset", 2'h3, {dos_n, lot_n});
      reg_read(rfd_pkg::REG_CTRL, rfd_pkg::CTRL_RESET);
      reg_write(rfd_pkg::REG_CTRL, 32'h0000_0000);
      reg_read(rfd_pkg::REG_CTRL, 32'h0000_0000);
      reg_write(rfd_pkg::REG_CTRL, rfd_pkg::CTRL_RESET);
      reg_read(8'hFC, 32'h0000_0000);
      // Second sample needed when the extremes still span the jump
      for (int i = 0; i < 11; i++) begin
         @(posedge clock);
         monitor_mag <= rows[i].mag;
         repeat (rows[i].smp) rfd_host_model_inst.pulse_sample();
         repeat (20) @(posedge clock);
         check("fault_flags", 32'(rows[i].flags), {dos_n, lot_n});
      end
      reg_read(rfd_pkg::REG_EXTREMES, 32'h0800_0800);
      reg_read(rfd_pkg::REG_STATUS, 32'h0000_0040);
      // Host restarts the part after a loss of signal
      @(posedge clock);
      monitor_mag <= 12'h0100;
      repeat (6) @(posedge clock);
      check("los_flags", 2'h0, {dos_n, lot_n});
      reg_read(rfd_pkg::REG_STATUS, 32'h0000_0045);
      @(posedge clock);
      monitor_mag <= 12'h0800;
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      check("reset_pins", 14'h3FFF, {dos_n, lot_n, elev_oe_n, ten_oe_n, low_oe_n});
      rstn <= 1'b1;
      repeat (10) @(posedge clock);
      check("after_reset", 2'h3, {dos_n, lot_n});
      @(posedge clock);
      input_angle <= 12'h0050;
      repeat (6) @(posedge clock);
      check("lot_error", 2'h2, {dos_n, lot_n});
      rfd_host_model_inst.read_word(1'b1, d, oe);
      check("oe_in_fault", 12'h000, oe);
      repeat (200) @(posedge clock);
      check("lot_held_gap", 2'h2, {dos_n, lot_n});
      rfd_host_model_inst.pulse_sample();
      check("lot_clear", 2'h3, {dos_n, lot_n});
      rfd_host_model_inst.read_word(1'b1, p, oe);
      check("position", 1'b1, 32'((p - 12'h0050) <= 12'h0001));
      check("par_oe", 12'h000, oe);
      rfd_host_model_inst.read_word(1'b0, d, oe);
      check("velocity", 1'b1, 32'(d <= 12'h0050));
      @(posedge clock);
      ser_n <= 1'b0;
      repeat (10) @(posedge clock);
      rfd_host_model_inst.read_serial(w, oe);
      check("ser_oe", 12'h7FF, oe);
      check("ser_word", {p, 3'h7}, 32'(w[15:1]));
      check("ser_parity", 1'b1, 32'(^w));
      for (int i = 0; i < 4; i++) exc_half(2'(3 - i), halves[i]);
      conclude();
   end
endmodule

// ==== test/rfd_host_model.sv ====
// Host controller model for the sample, read and serial pins
`timescale 1ns/1ps
module rfd_host_model (
   // Clock
   input wire logic clock,
   // Control pins
   output logic sample_n,
   output logic chip_select_n,
   output logic read_n,
   output logic position_velocity_select,
   output logic serial_clock,
   // Data pins
   input wire logic [11:0] data_pins,
   input wire logic [11:0] oe_pins,
   input wire logic serial_out
);
   initial begin
      sample_n = 1'b1;
      chip_select_n = 1'b1;
      read_n = 1'b1;
      position_velocity_select = 1'b1;
      serial_clock = 1'b1;
   end
   // ----------------------------------------------------------------
   // Pin sequences
   // ----------------------------------------------------------------
   // Long low phase, so a read never starts before the hold lands
   task automatic pulse_sample();
      @(posedge clock);
      sample_n <= 1'b0;
      repeat (10) @(posedge clock);
      sample_n <= 1'b1;
      repeat (10) @(posedge clock);
   endtask
   task automatic start_read(input logic pv);
      @(posedge clock);
      position_velocity_select <= pv;
      repeat (2) @(posedge clock);
      chip_select_n <= 1'b0;
      read_n <= 1'b0;
      repeat (12) @(posedge clock);
   endtask
   task automatic end_read();
      @(posedge clock);
      chip_select_n <= 1'b1;
      read_n <= 1'b1;
      repeat (12) @(posedge clock);
   endtask
   task automatic read_word(input logic pv, output logic [11:0] d, output logic [11:0] oe);
      start_read(pv);
      d = data_pins;
      oe = oe_pins;
      end_read();
   endtask
   // Serial clock runs only inside the frame, idle high, 80 ns period
   task automatic read_serial(output logic [15:0] w, output logic [11:0] oe);
      start_read(1'b1);
      oe = oe_pins;
      for (int i = 15; i >= 0; i--) begin
         w[i] = serial_out;
         serial_clock <= 1'b0;
         repeat (8) @(posedge clock);
         serial_clock <= 1'b1;
         repeat (8) @(posedge clock);
      end
      end_read();
   endtask
endmodule
